// *** rtl/wdtsel_map.vh ***
`ifndef WDTSEL_MAP_VH
`define WDTSEL_MAP_VH
// register byte addresses on apb
`define WDTSEL_TIMER_CONTROL_HIGH_ADDR 12'h000
`define WDTSEL_RESTART_ADDR 12'h004
`define WDTSEL_STATUS_ADDR 12'h008
// timer_control_high fields
`define WDTSEL_SEL_MSB 6
`define WDTSEL_SEL_LSB 4
`define WDTSEL_LOCK_MSB 7
`define WDTSEL_LOCK_LSB 3
`define WDTSEL_TCH_RESET 8'h70
// restart key written to restart register
`define WDTSEL_RESTART_KEY 8'h5A
// select field reset value, longest period
`define WDTSEL_SEL_RESET 3'h7
// crystal cycles to time-out per select code
`define WDTSEL_PERIOD_SEL1 23'h01_0000
`define WDTSEL_PERIOD_SEL2 23'h02_0000
`define WDTSEL_PERIOD_SEL3 23'h04_0000
`define WDTSEL_PERIOD_SEL4 23'h08_0000
`define WDTSEL_PERIOD_SEL5 23'h10_0000
`define WDTSEL_PERIOD_SEL6 23'h20_0000
`define WDTSEL_PERIOD_SEL7 23'h40_0000
`endif

// *** rtl/wdtsel_counter.v ***
`default_nettype none
module wdtsel_counter #(
   parameter CW = 23
) (
   input wire clock,
   input wire rst,
   input wire ce,
   input wire clear,
   input wire run,
   input wire [CW-1:0] limit,
   output reg expired
);
reg [CW-1:0] count_r;
always @(posedge clock or posedge rst) begin
   if (rst) begin
      count_r <= {CW{1'b0}};
      expired <= 1'b0;
   end else if (ce) begin
      if (clear || !run) begin
         count_r <= {CW{1'b0}};
         expired <= 1'b0;
      end else if (count_r >= limit) begin // limit may drop below count on rewrite
         count_r <= {CW{1'b0}};
         expired <= 1'b1;
      end else begin
         count_r <= count_r + {{(CW-1){1'b0}}, 1'b1};
         expired <= 1'b0;
      end
   end
end
endmodule // wdtsel_counter
`default_nettype wire

// *** rtl/wdtsel_top.v ***
// Notes on behaviour
// - upper five bits writable during first instruction
// - later upper-five-bit writes ignored until reset
// - select code picks period, 000 disables
// - select bits reset to 111, longest period
// - count advances every clock cycle that has ce high, except with select 000, on restart and on expiry
//
// Local design decisions: the APB interface to the registers and the register addresses.
`include "wdtsel_map.vh"
`default_nettype none
module wdtsel_top #(
   parameter CW = 23
) (
   input wire clock,
   input wire rst,
   input wire ce,
   input wire first_instr_done,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg internal_reset,
   output reg [2:0] period_select
);
////////////////////////////////////////////////////////////////////////
// first-instruction window states, one-hot
localparam [1:0] WIN_OPEN = 2'b01;
localparam [1:0] WIN_LOCKED = 2'b10;
////////////////////////////////////////////////////////////////////////
reg [7:0] tch_r;
reg [7:0] tch_nxt;
reg [1:0] win_r;
reg [1:0] win_nxt;
reg restart_r;
reg restart_nxt;
reg expired_seen_r;
reg hit_tch;
reg hit_rst;
reg hit_sts;
reg [CW-1:0] period;
reg [CW-1:0] limit;
reg [31:0] rdata_nxt;
wire expired;
wire acc;
wire wr;
wire rd;
wire hit_any;
wire key_ok;
wire window_open;
wire [2:0] sel;
wire run;
////////////////////////////////////////////////////////////////////////
// access qualifiers, one wait state before pready
assign acc = psel && penable && !pready;
assign wr = acc && pwrite;
assign rd = acc && !pwrite;
assign hit_any = hit_tch || hit_rst || hit_sts;
assign key_ok = (pwdata[7:0] == `WDTSEL_RESTART_KEY);
assign window_open = (win_r == WIN_OPEN);
assign sel = tch_r[`WDTSEL_SEL_MSB:`WDTSEL_SEL_LSB];
assign run = (sel != 3'b000);
////////////////////////////////////////////////////////////////////////
// address decode
always @* begin
   hit_tch = 1'b0;
   hit_rst = 1'b0;
   hit_sts = 1'b0;
   if (paddr == `WDTSEL_TIMER_CONTROL_HIGH_ADDR) begin
      hit_tch = 1'b1;
   end else if (paddr == `WDTSEL_RESTART_ADDR) begin
      hit_rst = 1'b1;
   end else if (paddr == `WDTSEL_STATUS_ADDR) begin
      hit_sts = 1'b1;
   end
end
////////////////////////////////////////////////////////////////////////
// crystal cycles per select code
always @* begin
   case (sel)
      3'b001: begin
         period = `WDTSEL_PERIOD_SEL1;
      end
      3'b010: begin
         period = `WDTSEL_PERIOD_SEL2;
      end
      3'b011: begin
         period = `WDTSEL_PERIOD_SEL3;
      end
      3'b100: begin
         period = `WDTSEL_PERIOD_SEL4;
      end
      3'b101: begin
         period = `WDTSEL_PERIOD_SEL5;
      end
      3'b110: begin
         period = `WDTSEL_PERIOD_SEL6;
      end
      3'b111: begin
         period = `WDTSEL_PERIOD_SEL7;
      end
      default: begin
         period = {CW{1'b0}};
      end
   endcase
end
// counter runs from zero to period minus one
always @* begin
   limit = {CW{1'b0}};
   if (run) begin
      limit = period - {{(CW-1){1'b0}}, 1'b1};
   end
end
////////////////////////////////////////////////////////////////////////
// write window shuts for good after first instruction
always @* begin
   win_nxt = win_r;
   case (win_r)
      WIN_OPEN: begin
         if (first_instr_done) begin
            win_nxt = WIN_LOCKED;
         end
      end
      WIN_LOCKED: begin
         win_nxt = WIN_LOCKED;
      end
      default: begin
         win_nxt = WIN_LOCKED;
      end
   endcase
end
////////////////////////////////////////////////////////////////////////
// control register write, upper bits only while open
always @* begin
   tch_nxt = tch_r;
   if (wr && hit_tch) begin
      tch_nxt[2:0] = pwdata[2:0];
      if (window_open) begin
         tch_nxt[`WDTSEL_LOCK_MSB:`WDTSEL_LOCK_LSB] = pwdata[`WDTSEL_LOCK_MSB:`WDTSEL_LOCK_LSB];
      end // upper bits held once shut
   end
end
// restart only on the key value
always @* begin
   restart_nxt = 1'b0;
   if (wr && hit_rst && key_ok) begin
      restart_nxt = 1'b1;
   end
end
// read mux, unused bits read zero
always @* begin
   rdata_nxt = 32'h0000_0000;
   if (rd) begin
      if (hit_tch) begin
         rdata_nxt = {24'h00_0000, tch_r};
      end else if (hit_sts) begin
         rdata_nxt = {30'h0000_0000, expired_seen_r, window_open};
      end
   end
end
////////////////////////////////////////////////////////////////////////
// control register and select output
always @(posedge clock or posedge rst) begin
   if (rst) begin
      tch_r <= `WDTSEL_TCH_RESET;
      period_select <= `WDTSEL_SEL_RESET;
   end else if (ce) begin
      tch_r <= tch_nxt;
      period_select <= tch_nxt[`WDTSEL_SEL_MSB:`WDTSEL_SEL_LSB];
   end
end
// window state
always @(posedge clock or posedge rst) begin
   if (rst) begin
      win_r <= WIN_OPEN;
   end else if (ce) begin
      win_r <= win_nxt;
   end
end
// restart strobe, expiry pulse and sticky flag
always @(posedge clock or posedge rst) begin
   if (rst) begin
      restart_r <= 1'b0;
      expired_seen_r <= 1'b0;
      internal_reset <= 1'b0;
   end else if (ce) begin
      restart_r <= restart_nxt;
      internal_reset <= expired;
      if (expired) begin
         expired_seen_r <= 1'b1;
      end
   end
end
////////////////////////////////////////////////////////////////////////
// apb answer, registered one cycle after access
always @(posedge clock or posedge rst) begin
   if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
   end else if (ce) begin
      pready <= acc;
      pslverr <= acc && !hit_any;
      prdata <= rdata_nxt;
   end
end
////////////////////////////////////////////////////////////////////////
// period counter, cleared by restart key
wdtsel_counter #(.CW(CW)) u_cnt (
   .clock(clock),
   .rst(rst),
   .ce(ce),
   .clear(restart_r),
   .run(run),
   .limit(limit),
   .expired(expired)
);
endmodule // wdtsel_top
`default_nettype wire

// *** verif/wdtsel_top_sva.sv ***
`default_nettype none
module wdtsel_top_sva(input wire logic clock, rst, psel, penable, pwrite, pready, first_instr_done,
   internal_reset, input wire logic [11:0] paddr, input wire logic [31:0] pwdata,
   input wire logic [2:0] period_select);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic seen_r;
   logic [23:0] cnt_r;
   wire acc = psel & penable & !pready;
   wire wr0 = acc & pwrite & paddr == 12'h000;
   // restart-relative cycle count
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         seen_r <= 1'b0;
         cnt_r <= 24'h00_0000;
      end else begin
         seen_r <= seen_r | first_instr_done;
         cnt_r <= (acc & pwrite & paddr == 12'h004 & pwdata[7:0] == 8'h5a) ? 24'h0 : cnt_r + 24'h1;
      end
   end
   a_sel_reset: assert property ($fell(rst) |-> period_select == 3'b111) else $error("sel");
   a_open_write: assert property (wr0 & !seen_r |=> period_select == $past(pwdata[6:4])) else $error("w");
   a_late_lock: assert property (wr0 & seen_r |=> $stable(period_select)) else $error("lock");
   a_only_write: assert property (!wr0 |=> $stable(period_select)) else $error("chg");
   a_off_quiet: assert property (period_select == 0 |=> !internal_reset) else $error("off");
   a_no_early: assert property (internal_reset |-> cnt_r + 2 >= (24'h1 << (15 + period_select))) else $error("e");
   c_open: cover property (wr0 & !seen_r);
   c_lock: cover property (wr0 & seen_r);
   c_exp: cover property (internal_reset);
endmodule // wdtsel_top_sva
bind wdtsel_top wdtsel_top_sva u_sva(.*);
`default_nettype wire

// *** verif/wdtsel_top_test.sv ***
`default_nettype none
module wdtsel_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, rst = 1, ce = 1, fid = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irst, er;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [2:0] sel;
   int miscompares = 0, n_tests = 0, k;
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; $display("[ERR] %s %h %h", n, e, s); end end
   wdtsel_top u_dut(.clock(clock), .rst(rst), .ce(ce), .first_instr_done(fid), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .internal_reset(irst), .period_select(sel));
   initial forever #2.5 clock = ~clock;
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1;
      do @(posedge clock); while (pready !== 1);
      rd = prdata; er = pslverr; psel <= 0; penable <= 0;
   endtask
   task do_reset;
      rst <= 1; fid <= 0;
      repeat (10) @(posedge clock);
      rst <= 0;
      @(posedge clock);
   endtask
   task results;
      $display("miscompares %0d n_tests %0d", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task t_lock;
      `CHK("sel", 3'b111, sel)
      apb(0, 12'h000, 0); `CHK("tch", 32'h70, rd)
      apb(0, 12'h008, 0); `CHK("sts", 32'h1, rd)
      apb(1, 12'h000, 32'h10); `CHK("sel", 3'b001, sel)
      fid <= 1;
      apb(1, 12'h000, 32'h77); apb(0, 12'h000, 0); `CHK("tch", 32'h17, rd)
      apb(0, 12'h008, 0); `CHK("sts", 32'h0, rd)
      apb(0, 12'hffc, 0); `CHK("err", 1'b1, er)
   endtask
   task t_expire;
      apb(1, 12'h004, 32'h5a);
      repeat (10) @(posedge clock);
      ce <= 0;
      repeat (100) @(posedge clock);
      ce <= 1;
      for (k = 110; irst !== 1 && k < 70000; k++) @(posedge clock);
      `CHK("exp", 1'b1, k > 65630 && k < 65640)
      @(posedge clock);
      `CHK("pulse", 1'b0, irst)
      apb(0, 12'h008, 0); `CHK("sts", 32'h2, rd)
   endtask
   task t_off;
      do_reset;
      `CHK("sel", 3'b111, sel)
      apb(1, 12'h000, 0); `CHK("sel", 3'b000, sel)
      fid <= 1;
      apb(1, 12'h000, 32'h75); `CHK("sel", 3'b000, sel)
      apb(0, 12'h000, 0); `CHK("tch", 32'h05, rd)
   endtask
   initial begin
      #450000;
      miscompares++;
      results;
   end
   initial begin
      do_reset;
      t_lock;
      t_expire;
      t_off;
      results;
   end
endmodule // wdtsel_top_test
`default_nettype wire
